// *** shared/burst4_sram_defs.svh ***
`ifndef BURST4_SRAM_DEFS_SVH
`define BURST4_SRAM_DEFS_SVH

// Array geometry: words per burst and bits per byte lane.
`define BURST_WORDS      4
`define BYTE_LANE_W      9

// Default configuration: 18-bit words, 21-bit burst address.
`define DEF_WORD_W       18
`define DEF_ADDR_W       21

// Period of the system clock in nanoseconds.
`define SYS_PERIOD_NS    20

// PLL lock time after a stable input clock, in microseconds, and in system cycles.
`define PLL_LOCK_US      20
`define PLL_LOCK_CYC     ((`PLL_LOCK_US * 1000 + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)

// Input clock stop that resets the PLL, in nanoseconds, and in system cycles.
`define PLL_STOP_NS      30
`define PLL_STOP_CYC     ((`PLL_STOP_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)

// Output impedance recalibration interval in input clock cycles.
`define IMP_CAL_CYC      1024

`endif

// *** shared/burst4_sram_pkg.sv ***
package burst4_sram_pkg;

    // PLL tracking states, one-hot.
    typedef enum logic [2:0] {
        PLL_OFF_S  = 3'b001,
        PLL_ACQ_S  = 3'b010,
        PLL_LOCK_S = 3'b100
    } pll_state_t;

endpackage

// *** core/burst_line_store.sv ***
`timescale 1ns/1ns
`include "burst4_sram_defs.svh"

module burst_line_store
#(
    parameter int ADDR_W = `DEF_ADDR_W,
    parameter int WORD_W = `DEF_WORD_W
)
(
    // Clock.
    input  wire logic                                 clk_i,
    // Write side: one whole burst line with per-lane enables.
    input  wire logic                                 wr_en_i,
    input  wire logic [ADDR_W-1:0]                    wr_addr_i,
    input  wire logic [`BURST_WORDS*WORD_W-1:0]       wr_line_i,
    input  wire logic [`BURST_WORDS*WORD_W/`BYTE_LANE_W-1:0] wr_lane_en_i,
    // Read side: combinational line fetch.
    input  wire logic [ADDR_W-1:0]                    rd_addr_i,
    output logic      [`BURST_WORDS*WORD_W-1:0]       rd_line_o
);

    localparam int LINE_W  = `BURST_WORDS * WORD_W;
    localparam int N_LANES = LINE_W / `BYTE_LANE_W;

    // Storage is plain flip-flops; word k of a line is burst address base plus k.
    logic [LINE_W-1:0] mem [2**ADDR_W];

    // Lanes with a clear enable keep their old contents.
    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            for (int b = 0; b < N_LANES; b++)
            begin
                if (wr_lane_en_i[b])
                begin
                    mem[wr_addr_i][b*`BYTE_LANE_W +: `BYTE_LANE_W] <=
                        wr_line_i[b*`BYTE_LANE_W +: `BYTE_LANE_W];
                end
            end
        end
    end

    // Read path is asynchronous so the caller can merge forwarded data.
    assign rd_line_o = mem[rd_addr_i];

endmodule

// *** core/burst4_sram_if.sv ***
// Operation
// - PLL enabled: first read word appears two true clock rises after the read start.
// - PLL disabled: legacy mode, first read word one true clock rise after start.
// - Port selects sampled only on true clock rises; accesses start only there.
// - Read select low at a true rise latches the address as read address.
// - Each access moves four words in two cycles, one per true/complement rise.
// - After the latency the base word comes first, then one word per alternating rise.
// - A read request on the rise right after a read start is ignored.
// - Read port deselected: finish pending burst, then float outputs after next true rise.
// - Write data follows the write start on next two cycles; line written afterwards.
// - A write request on the rise right after a write start is ignored.
// - Write port deselected: finish pending write, then ignore write inputs.
// - Byte lane selects sampled per word; low writes lane, high keeps old contents.
// - Read and write ports work independently on any location.
// - PLL enabled: read of address written by previous-rise write returns the new data; legacy mode returns the old data.
// - Both selects, nothing started before: read goes first.
// - Both selects after a read start: write is granted.
// - Both selects after a write start: read is granted.
// - Deselecting one port leaves the other alone; pending bursts always finish.
// - Output impedance recalibrated every 1024 input clock cycles after power-up.
// - Two free-running echo clocks follow the true and complement input clocks.
// - Valid flag has read data timing and rises half a cycle before first word.
// - PLL counts as locked only after 20 us of stable input clock.
// - After reset both ports are deselected and read outputs float.
// - A burst uses base address, then base plus one, two and three in order.
`timescale 1ns/1ns
`include "burst4_sram_defs.svh"

module burst4_sram_if
    import burst4_sram_pkg::*;
#(
    parameter int ADDR_W = `DEF_ADDR_W,
    parameter int WORD_W = `DEF_WORD_W
)
(
    // System clock and reset.
    input  wire logic                          CLK_SYS_I,
    input  wire logic                          RST_N_I,
    // Link clocks: true and complement input clocks.
    input  wire logic                          K_CLK_I,
    input  wire logic                          KB_CLK_I,
    // Command and write data, sampled on the link clocks.
    input  wire logic                          READ_PORT_SELECT_N_I,
    input  wire logic                          WRITE_PORT_SELECT_N_I,
    input  wire logic [ADDR_W-1:0]             ADDR_I,
    input  wire logic [WORD_W-1:0]             WDATA_I,
    input  wire logic [WORD_W/`BYTE_LANE_W-1:0] BYTE_LANE_WRITE_SELECT_N_I,
    // Static strap.
    input  wire logic                          PLL_DISABLE_N_I,
    // Read data: word launched on the true rise, word launched on the complement rise.
    output logic      [WORD_W-1:0]             Q_K_O,
    output logic      [WORD_W-1:0]             Q_KB_O,
    output logic                               Q_OE_O,
    output logic                               OUTPUT_VALID_FLAG_O,
    // Echo clocks.
    output logic                               ECHO_TIMING_TRUE_O,
    output logic                               ECHO_TIMING_COMP_O,
    // Status.
    output logic                               PLL_LOCKED_O,
    output logic                               IMP_CAL_O
);

    localparam int LANES  = WORD_W / `BYTE_LANE_W;
    localparam int LINE_W = `BURST_WORDS * WORD_W;
    localparam int LLAN_W = `BURST_WORDS * LANES;

    // Overlay a committing line on array data lane by lane.
    function automatic logic [LINE_W-1:0] merge_line(
        input logic [LINE_W-1:0] old_line,
        input logic [LINE_W-1:0] new_line,
        input logic [LLAN_W-1:0] lane_en
    );
        logic [LINE_W-1:0] res;
        res = old_line;
        for (int b = 0; b < LLAN_W; b++)
        begin
            if (lane_en[b])
            begin
                res[b*`BYTE_LANE_W +: `BYTE_LANE_W] = new_line[b*`BYTE_LANE_W +: `BYTE_LANE_W];
            end
        end
        return res;
    endfunction

    // ---------------- Link domain, true clock ----------------

    logic              pll_n_s1_r;
    logic              pll_n_s2_r;
    logic              rd_prev_r;
    logic              wr_prev_r;
    logic              rd_st1_r;
    logic              wr_st1_r;
    logic              wr_st2_r;
    logic [ADDR_W-1:0] rd_addr_r;
    logic [ADDR_W-1:0] wr_addr_r;
    logic [ADDR_W-1:0] wr_cmt_addr_r;
    logic [WORD_W-1:0] asm_w0_r;
    logic [WORD_W-1:0] asm_w1_r;
    logic [WORD_W-1:0] asm_w2_r;
    logic [LANES-1:0]  asm_en0_r;
    logic [LANES-1:0]  asm_en1_r;
    logic [LANES-1:0]  asm_en2_r;
    logic [WORD_W-1:0] q_k_r;
    logic [WORD_W-1:0] kb_word_r;
    logic [WORD_W-1:0] rd_w2_r;
    logic [WORD_W-1:0] rd_w3_r;
    logic              q_second_r;
    logic              q_oe_r;
    logic              ech_a_r;
    logic              hb_r;
    logic [9:0]        cal_cnt_r;
    logic              imp_cal_r;

    // Complement clock captures.
    logic [WORD_W-1:0] kb_d_r;
    logic [LANES-1:0]  kb_bws_n_r;
    logic [WORD_W-1:0] q_kb_r;
    logic              vld_r;
    logic              ech_b_r;

    // Arbitration and command decode.
    wire legacy  = ~pll_n_s2_r;
    wire rd_req  = ~READ_PORT_SELECT_N_I & ~rd_prev_r;
    wire wr_req  = ~WRITE_PORT_SELECT_N_I & ~wr_prev_r;
    wire rd_go   = rd_req;
    wire wr_go   = wr_req & ~rd_req;
    wire rd_load = legacy ? rd_prev_r : rd_st1_r;

    // Array access: commit line, fetched line, forwarded line.
    wire              cmt_en  = wr_st2_r;
    wire [LINE_W-1:0] cmt_line = {kb_d_r, asm_w2_r, asm_w1_r, asm_w0_r};
    wire [LLAN_W-1:0] cmt_lane = {~kb_bws_n_r, asm_en2_r, asm_en1_r, asm_en0_r};
    wire [LINE_W-1:0] arr_line;
    wire              fwd_hit = cmt_en & (wr_cmt_addr_r == rd_addr_r);
    wire [LINE_W-1:0] rd_line = fwd_hit ? merge_line(arr_line, cmt_line, cmt_lane)
                                        : arr_line;
    wire              vld_src = rd_load | q_second_r;

    burst_line_store #(
        .ADDR_W (ADDR_W),
        .WORD_W (WORD_W)
    ) u_store (
        .clk_i        (K_CLK_I),
        .wr_en_i      (cmt_en),
        .wr_addr_i    (wr_cmt_addr_r),
        .wr_line_i    (cmt_line),
        .wr_lane_en_i (cmt_lane),
        .rd_addr_i    (rd_addr_r),
        .rd_line_o    (arr_line)
    );

    // The strap is a pin, so it is synchronised before the latency select reads it.
    always_ff @(posedge K_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            pll_n_s1_r <= 1'b1;
            pll_n_s2_r <= 1'b1;
        end
        else
        begin
            pll_n_s1_r <= PLL_DISABLE_N_I;
            pll_n_s2_r <= pll_n_s1_r;
        end
    end

    // Start tracking; only one access starts per true rise on the shared address bus.
    always_ff @(posedge K_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rd_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
            rd_st1_r  <= 1'b0;
            wr_st1_r  <= 1'b0;
            wr_st2_r  <= 1'b0;
        end
        else
        begin
            rd_prev_r <= rd_go;
            wr_prev_r <= wr_go;
            rd_st1_r  <= rd_prev_r;
            wr_st1_r  <= wr_prev_r;
            wr_st2_r  <= wr_st1_r;
        end
    end

    // Address latches; each port keeps its own copy so neither disturbs the other.
    always_ff @(posedge K_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rd_addr_r     <= '0;
            wr_addr_r     <= '0;
            wr_cmt_addr_r <= '0;
        end
        else
        begin
            if (rd_go)
            begin
                rd_addr_r <= ADDR_I;
            end
            if (wr_go)
            begin
                wr_addr_r <= ADDR_I;
            end
            if (wr_st1_r)
            begin
                wr_cmt_addr_r <= wr_addr_r;
            end
        end
    end

    // Write data assembly: word 0 at t+1, words 1 and 2 at t+2, word 3 joins at commit.
    always_ff @(posedge K_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            asm_w0_r  <= '0;
            asm_w1_r  <= '0;
            asm_w2_r  <= '0;
            asm_en0_r <= '0;
            asm_en1_r <= '0;
            asm_en2_r <= '0;
        end
        else
        begin
            if (wr_prev_r)
            begin
                asm_w0_r  <= WDATA_I;
                asm_en0_r <= ~BYTE_LANE_WRITE_SELECT_N_I;
            end
            if (wr_st1_r)
            begin
                asm_w1_r  <= kb_d_r;
                asm_en1_r <= ~kb_bws_n_r;
                asm_w2_r  <= WDATA_I;
                asm_en2_r <= ~BYTE_LANE_WRITE_SELECT_N_I;
            end
        end
    end

    // Read output sequencer: base word, then base plus one to three on alternate rises.
    always_ff @(posedge K_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            q_k_r      <= '0;
            kb_word_r  <= '0;
            rd_w2_r    <= '0;
            rd_w3_r    <= '0;
            q_second_r <= 1'b0;
            q_oe_r     <= 1'b0;
        end
        else if (rd_load)
        begin
            q_k_r      <= rd_line[0*WORD_W +: WORD_W];
            kb_word_r  <= rd_line[1*WORD_W +: WORD_W];
            rd_w2_r    <= rd_line[2*WORD_W +: WORD_W];
            rd_w3_r    <= rd_line[3*WORD_W +: WORD_W];
            q_second_r <= 1'b1;
            q_oe_r     <= 1'b1;
        end
        else if (q_second_r)
        begin
            q_k_r      <= rd_w2_r;
            kb_word_r  <= rd_w3_r;
            q_second_r <= 1'b0;
        end
        else
        begin
            q_oe_r <= 1'b0;
        end
    end

    // Echo half, a heartbeat toggling every second rise so the 20 ns sampler misses no change,
    // and the recalibration timer.
    always_ff @(posedge K_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ech_a_r   <= 1'b0;
            hb_r      <= 1'b0;
            cal_cnt_r <= '0;
            imp_cal_r <= 1'b0;
        end
        else
        begin
            ech_a_r   <= ~ech_b_r;
            hb_r      <= hb_r ^ cal_cnt_r[0];
            cal_cnt_r <= cal_cnt_r + 10'h001;
            imp_cal_r <= (cal_cnt_r == 10'(`IMP_CAL_CYC - 1));
        end
    end

    // ---------------- Link domain, complement clock ----------------

    // The complement clock shares the true clock's source, so its words are
    // handed over with half a cycle of margin rather than a synchroniser.
    always_ff @(posedge KB_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            kb_d_r     <= '0;
            kb_bws_n_r <= '1;
            q_kb_r     <= '0;
            vld_r      <= 1'b0;
            ech_b_r    <= 1'b0;
        end
        else
        begin
            kb_d_r     <= WDATA_I;
            kb_bws_n_r <= BYTE_LANE_WRITE_SELECT_N_I;
            q_kb_r     <= kb_word_r;
            vld_r      <= vld_src;
            ech_b_r    <= ech_a_r;
        end
    end

    // ---------------- System domain: PLL lock monitor ----------------

    logic                hb_s1_r;
    logic                hb_s2_r;
    logic                hb_s3_r;
    logic                pn_s1_r;
    logic                pn_s2_r;
    logic [1:0]          idle_cnt_r;
    logic [10:0]         lock_cnt_r;
    pll_state_t          pll_state_r;
    pll_state_t          pll_state_nxt;
    logic                locked_r;

    wire clk_alive = hb_s2_r ^ hb_s3_r;
    wire clk_stop  = (idle_cnt_r == 2'(`PLL_STOP_CYC));
    wire lock_done = (lock_cnt_r == 11'(`PLL_LOCK_CYC - 1));

    // Heartbeat and strap synchronisers; the second stages and the third heartbeat stage feed logic.
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            hb_s1_r <= 1'b0;
            hb_s2_r <= 1'b0;
            hb_s3_r <= 1'b0;
            pn_s1_r <= 1'b1;
            pn_s2_r <= 1'b1;
        end
        else
        begin
            hb_s1_r <= hb_r;
            hb_s2_r <= hb_s1_r;
            hb_s3_r <= hb_s2_r;
            pn_s1_r <= PLL_DISABLE_N_I;
            pn_s2_r <= pn_s1_r;
        end
    end

    // A stop of two system cycles cannot be an alias of a running link clock as long as the
    // heartbeat changes once per 20 to 40 ns, which limits the monitor to 10 to 20 ns periods.
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            idle_cnt_r <= '0;
        end
        else if (clk_alive)
        begin
            idle_cnt_r <= '0;
        end
        else if (!clk_stop)
        begin
            idle_cnt_r <= idle_cnt_r + 2'h1;
        end
    end

    // Lock state machine.
    always_comb
    begin
        case (pll_state_r)
            PLL_OFF_S:  pll_state_nxt = pn_s2_r ? PLL_ACQ_S : PLL_OFF_S;
            PLL_ACQ_S:  pll_state_nxt = !pn_s2_r ? PLL_OFF_S :
                                        (lock_done && !clk_stop) ? PLL_LOCK_S : PLL_ACQ_S;
            PLL_LOCK_S: pll_state_nxt = (!pn_s2_r || clk_stop) ? PLL_OFF_S : PLL_LOCK_S;
            default:    pll_state_nxt = PLL_OFF_S;
        endcase
    end

    // Lock counter restarts whenever the input clock stalls.
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            pll_state_r <= PLL_OFF_S;
            lock_cnt_r  <= '0;
            locked_r    <= 1'b0;
        end
        else
        begin
            pll_state_r <= pll_state_nxt;
            locked_r    <= (pll_state_nxt == PLL_LOCK_S);
            if (pll_state_r != PLL_ACQ_S || clk_stop)
            begin
                lock_cnt_r <= '0;
            end
            else if (!lock_done)
            begin
                lock_cnt_r <= lock_cnt_r + 11'h001;
            end
        end
    end

    // Output drive. Echo clocks are the exclusive-or of a true and a complement
    // flip-flop; a single register cannot change on both clocks.
    assign Q_K_O               = q_k_r;
    assign Q_KB_O              = q_kb_r;
    assign Q_OE_O              = q_oe_r;
    assign OUTPUT_VALID_FLAG_O = vld_r;
    assign ECHO_TIMING_TRUE_O  = ech_a_r ^ ech_b_r;
    assign ECHO_TIMING_COMP_O  = ~(ech_a_r ^ ech_b_r);
    assign PLL_LOCKED_O        = locked_r;
    assign IMP_CAL_O           = imp_cal_r;

endmodule

// *** testbench/burst4_sram_properties.sv ***
`timescale 1ns/1ns
`include "burst4_sram_defs.svh"

module burst4_sram_checker
(
    // Clocks and reset.
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic K_CLK_I,
    // Watched ports.
    input wire logic READ_PORT_SELECT_N_I,
    input wire logic PLL_DISABLE_N_I,
    input wire logic Q_OE_O,
    input wire logic OUTPUT_VALID_FLAG_O,
    input wire logic ECHO_TIMING_TRUE_O,
    input wire logic ECHO_TIMING_COMP_O,
    input wire logic PLL_LOCKED_O,
    input wire logic IMP_CAL_O
);
    localparam int LOCK_C = `PLL_LOCK_CYC;

    logic        rd_g_r;
    logic        rd_go;
    logic        cal_seen_r;
    logic [2:0]  idle_r;
    logic [10:0] cal_cnt_r;
    logic [10:0] lk_cnt_r;

    // A read request right after a granted one is not a start.
    assign rd_go = !READ_PORT_SELECT_N_I && !rd_g_r;

    // Read spacing and pulse spacing; the first pulse gap is not judged.
    always_ff @(posedge K_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rd_g_r     <= 1'b0;
            idle_r     <= 3'h7;
            cal_seen_r <= 1'b0;
            cal_cnt_r  <= 11'h0;
        end
        else
        begin
            rd_g_r     <= rd_go;
            idle_r     <= rd_go ? 3'h0 : idle_r + {2'h0, idle_r != 3'h7};
            cal_seen_r <= cal_seen_r | IMP_CAL_O;
            cal_cnt_r  <= IMP_CAL_O ? 11'h0 : cal_cnt_r + 11'h1;
        end
    end

    // Saturating count of system cycles since reset.
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            lk_cnt_r <= 11'h0;
        else
            lk_cnt_r <= lk_cnt_r + {10'h0, lk_cnt_r != 11'h7FF};
    end

    rd_lat_pll_a : assert property (
        @(posedge K_CLK_I) disable iff (!RST_N_I) rd_go && PLL_DISABLE_N_I |-> ##3 Q_OE_O)
        else $error("read data late in pll mode");
    rd_lat_leg_a : assert property (
        @(posedge K_CLK_I) disable iff (!RST_N_I) rd_go && !PLL_DISABLE_N_I |-> ##2 Q_OE_O)
        else $error("read data late in legacy mode");
    valid_lead_a : assert property (
        @(posedge K_CLK_I) disable iff (!RST_N_I)
        rd_go && PLL_DISABLE_N_I |-> ##2 OUTPUT_VALID_FLAG_O ##1 OUTPUT_VALID_FLAG_O)
        else $error("valid flag not ahead of read data");
    oe_release_a : assert property (
        @(posedge K_CLK_I) disable iff (!RST_N_I)
        idle_r >= (PLL_DISABLE_N_I ? 3'h4 : 3'h3) |-> !Q_OE_O)
        else $error("read outputs still driven after burst");
    echo_phase_a : assert property (
        @(posedge K_CLK_I) disable iff (!RST_N_I) !ECHO_TIMING_TRUE_O && ECHO_TIMING_COMP_O)
        else $error("echo clocks out of phase");
    cal_period_a : assert property (
        @(posedge K_CLK_I) disable iff (!RST_N_I) IMP_CAL_O && cal_seen_r |-> cal_cnt_r == 1023)
        else $error("calibration spacing wrong");
    lock_early_a : assert property (
        @(posedge CLK_SYS_I) disable iff (!RST_N_I) lk_cnt_r < LOCK_C |-> !PLL_LOCKED_O)
        else $error("lock reported too early");
    lock_late_a : assert property (
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        lk_cnt_r > LOCK_C + 20 && PLL_DISABLE_N_I |-> PLL_LOCKED_O)
        else $error("lock not reported");
endmodule

bind burst4_sram_if burst4_sram_checker burst4_sram_checker_i (
    .CLK_SYS_I            (CLK_SYS_I),
    .RST_N_I              (RST_N_I),
    .K_CLK_I              (K_CLK_I),
    .READ_PORT_SELECT_N_I (READ_PORT_SELECT_N_I),
    .PLL_DISABLE_N_I      (PLL_DISABLE_N_I),
    .Q_OE_O               (Q_OE_O),
    .OUTPUT_VALID_FLAG_O  (OUTPUT_VALID_FLAG_O),
    .ECHO_TIMING_TRUE_O   (ECHO_TIMING_TRUE_O),
    .ECHO_TIMING_COMP_O   (ECHO_TIMING_COMP_O),
    .PLL_LOCKED_O         (PLL_LOCKED_O),
    .IMP_CAL_O            (IMP_CAL_O)
);

// *** testbench/burst4_read_capture.sv ***
`timescale 1ns/1ns

module burst4_read_capture
(
    // Link clocks.
    input  wire logic        k_clk_i,
    input  wire logic        kb_clk_i,
    // Read port of the memory.
    input  wire logic        q_oe_i,
    input  wire logic [17:0] q_k_i,
    input  wire logic [17:0] q_kb_i,
    // Captured word; the toggle marks each new one.
    output logic      [17:0] word_o,
    output logic             tgl_o
);
    initial tgl_o = 1'b0;

    // Each half is taken one edge later, when it has settled for half a cycle.
    always @(posedge kb_clk_i)
    begin
        if (q_oe_i === 1'b1)
        begin
            word_o <= q_k_i;
            tgl_o  <= ~tgl_o;
        end
    end

    // The enable is seen before this edge moves it, so the last word is kept.
    always @(posedge k_clk_i)
    begin
        if (q_oe_i === 1'b1)
        begin
            word_o <= q_kb_i;
            tgl_o  <= ~tgl_o;
        end
    end
endmodule

// *** testbench/burst4_sram_if_tb.sv ***
`timescale 1ns/1ns

module burst4_sram_if_tb;
    logic        clk_sys = 1'b0;
    logic        k_clk = 1'b0;
    logic        kb_clk;
    logic        rst_n = 1'b0;
    logic        k_run = 1'b1;
    logic        rsel_n = 1'b1;
    logic        wsel_n = 1'b1;
    logic        pll_n = 1'b1;
    logic        rg_r = 1'b0;
    logic        wg_r = 1'b0;
    logic        lanes_rand = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [17:0] wdata = 18'h0;
    logic [1:0]  bws_n = 2'h0;
    logic [17:0] q_k;
    logic [17:0] q_kb;
    logic        q_oe;
    logic        locked;
    logic        cal;
    logic [17:0] word;
    logic        tgl;
    logic [17:0] mem [64];
    logic [17:0] wd [7];
    logic [1:0]  wb [7];
    logic [17:0] exp_q [$];
    integer      seed = 15;
    integer      fail_count = 0;
    integer      n_checks = 0;
    integer      cal_n = 0;
    integer      cyc = 0;
    integer      c0 = 0;
    integer      i;

    // The link clock has its own period and phase; clearing k_run parks it low.
    always #10 clk_sys = ~clk_sys;
    initial
    begin
        #3;
        forever #6 k_clk = ~k_clk & k_run;
    end
    assign kb_clk = ~k_clk;

    burst4_sram_if #(.ADDR_W(4), .WORD_W(18)) burst4_sram_if_i (
        .CLK_SYS_I                  (clk_sys),
        .RST_N_I                    (rst_n),
        .K_CLK_I                    (k_clk),
        .KB_CLK_I                   (kb_clk),
        .READ_PORT_SELECT_N_I       (rsel_n),
        .WRITE_PORT_SELECT_N_I      (wsel_n),
        .ADDR_I                     (addr),
        .WDATA_I                    (wdata),
        .BYTE_LANE_WRITE_SELECT_N_I (bws_n),
        .PLL_DISABLE_N_I            (pll_n),
        .Q_K_O                      (q_k),
        .Q_KB_O                     (q_kb),
        .Q_OE_O                     (q_oe),
        .OUTPUT_VALID_FLAG_O        (),
        .ECHO_TIMING_TRUE_O         (),
        .ECHO_TIMING_COMP_O         (),
        .PLL_LOCKED_O               (locked),
        .IMP_CAL_O                  (cal)
    );

    burst4_read_capture burst4_read_capture_i (
        .k_clk_i  (k_clk),
        .kb_clk_i (kb_clk),
        .q_oe_i   (q_oe),
        .q_k_i    (q_k),
        .q_kb_i   (q_kb),
        .word_o   (word),
        .tgl_o    (tgl)
    );

    task check(input string nm, input logic [17:0] got, input logic [17:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task wrap_up;
        if (fail_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One true clock cycle; slot 0 meets the complement rise, slot 1 the command's true
    // rise, so a write granted now owns slots 3 to 6.
    task tick(input logic r, input logic w, input logic [3:0] a);
        logic       rg;
        logic       wg;
        logic [1:0] b;
        integer     k;
        rg = r && !rg_r;
        wg = w && !wg_r && !rg;
        for (k = 0; k < 7; k++)
        begin
            wd[k] = k < 5 ? wd[k+2] : 18'($random(seed));
            wb[k] = k < 5 ? wb[k+2] : 2'h0;
        end
        for (k = 0; k < 4; k++)
        begin
            b = lanes_rand ? 2'($random(seed)) : 2'h0;
            if (rg)
                exp_q.push_back(mem[{a, k[1:0]}]);
            if (wg)
            begin
                wb[k+3] = b;
                if (!b[0]) mem[{a, k[1:0]}][8:0] = wd[k+3][8:0];
                if (!b[1]) mem[{a, k[1:0]}][17:9] = wd[k+3][17:9];
            end
        end
        rsel_n = !r;
        wsel_n = !w;
        addr = a;
        wdata = wd[0];
        bws_n = wb[0];
        @(posedge kb_clk);
        #3;
        wdata = wd[1];
        bws_n = wb[1];
        @(posedge k_clk);
        #3;
        rg_r = rg;
        wg_r = wg;
    endtask

    // Legacy mode loads a read before the previous rise's write commits, so a read never directly follows a write there.
    task rand_tick;
        logic [31:0] v;
        v = $random(seed);
        tick(v[0] && !(wg_r && !pll_n), v[1], v[5:2]);
    endtask

    task do_reset;
        rst_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        check("oe in reset", {17'h0, q_oe}, 18'h0);
        rst_n = 1'b1;
        rg_r = 1'b0;
        wg_r = 1'b0;
        @(posedge k_clk);
        #3;
        repeat (3) tick(1'b0, 1'b0, 4'h0);
    endtask

    // Every captured word must be the oldest one expected.
    always @(tgl)
    begin
        if ($time > 0 && exp_q.size() == 0)
            check("surplus words", 18'h1, 18'h0);
        else if ($time > 0)
            check("read word", word, exp_q.pop_front());
    end

    // Pulse count, and a ceiling well above the planned run length.
    always @(posedge k_clk)
        if (cal === 1'b1) cal_n++;
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    initial
    begin
        foreach (wd[k])
        begin
            wd[k] = 18'h0;
            wb[k] = 2'h0;
        end
        do_reset();
        for (i = 0; i < 16; i++)
        begin
            tick(1'b0, 1'b1, i[3:0]);
            tick(1'b0, 1'b0, 4'h0);
        end
        lanes_rand = 1'b1;
        tick(1'b0, 1'b1, 4'h5);
        tick(1'b1, 1'b0, 4'h5);
        tick(1'b0, 1'b0, 4'h0);
        tick(1'b1, 1'b1, 4'h6);
        tick(1'b1, 1'b1, 4'h7);
        tick(1'b1, 1'b1, 4'h6);
        repeat (2200) rand_tick();
        repeat (8) tick(1'b0, 1'b0, 4'h0);
        check("locked", {17'h0, locked}, 18'h1);
        check("cal pulses", {17'h0, cal_n >= 2}, 18'h1);
        check("left over", 18'(exp_q.size()), 18'h0);
        c0 = cyc;
        k_run = 1'b0;
        @(negedge locked);
        check("stop unlocks", {17'h0, cyc - c0 <= 10}, 18'h1);
        pll_n = 1'b0;
        k_run = 1'b1;
        do_reset();
        repeat (100) rand_tick();
        repeat (8) tick(1'b0, 1'b0, 4'h0);
        check("legacy lock", {17'h0, locked}, 18'h0);
        check("legacy left", 18'(exp_q.size()), 18'h0);
        wrap_up();
    end
endmodule
